//--- design/bmad_decoder.v
// branch-format and memory-access instruction decoder with effective address unit and apb registers
//
// Our own choices: the register offsets and the APB slave port.
`timescale 1ns/10ps
`include "bmad_map.vh"

// Behaviour
// - branch-format words give an 8-bit opcode and no register operands.
// - branch displacement is a signed 22-bit word count.
// - branch target is next instruction address plus displacement times four.
// - return ignores the displacement and produces no target.
// - bit 12 picks short (clear) or long (set); only long fetches a displacement word.
// - both memory variants carry an 8-bit opcode; loads, stores, transfers decode here.
// - for loads the register field names the first destination register.
// - for stores the register field names the first source register.
// - short variant, mode clear: address is the offset alone, base ignored.
// - short variant, mode set: address is base register contents plus offset.
// - short offset is an unsigned byte offset.
// - long mode 0100 is base alone; 0111 is base plus scaled index.
// - modes 1100..1111 add displacement to nothing, base, scaled index, or both.
// - long mode 0101 is current instruction address plus displacement plus eight.
// - long mode 0110 raises an invalid-opcode fault, no address.
// - scale 000..100 multiplies the index by 1, 2, 4, 8 or 16.
// - scale 101..111 raises an invalid-opcode fault; the code raises it only in the index modes 0111, 1110 and 1111.
// - the long displacement is the next word, a signed 32-bit value.
// - base and index fields select registers whose contents are used.
// - base addresses are virtual or physical per the virt bit of the control register.
// - extended transfer opcodes use the effective address as their target.
module bmad_decoder #(
  parameter [7:0] RETURN_OPC = 8'h0a,
  parameter [7:0] XBRANCH_OPC = 8'h84,
  parameter [7:0] XBAL_OPC = 8'h85,
  parameter [7:0] XCALL_OPC = 8'h86
) (
  // clock and reset
  input wire i_core_clk,
  input wire i_reset_n,
  // apb slave
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [11:0] i_paddr,
  input wire [31:0] i_pwdata,
  output reg [31:0] o_prdata,
  output reg o_pready,
  output reg o_pslverr,
  // fetch stage
  input wire i_insn_valid,
  input wire i_insn_fmt,
  input wire [31:0] i_insn_word,
  input wire [31:0] i_insn_addr,
  output reg o_insn_ready,
  // register file read ports
  output reg [4:0] o_rf_base_sel,
  output reg [4:0] o_rf_index_sel,
  input wire [31:0] i_rf_base_data,
  input wire [31:0] i_rf_index_data,
  // decoded result
  output reg o_dec_valid,
  output reg o_dec_fault,
  output reg o_dec_is_mem,
  output reg [7:0] o_dec_opcode,
  output reg [4:0] o_dec_reg,
  output reg [31:0] o_dec_addr,
  output reg o_dec_virt,
  output reg o_dec_xfer,
  output reg [31:0] o_dec_target
);

  // ----------------------------------------------------------------
  // state and working registers
  // ----------------------------------------------------------------
  localparam [3:0] S_IDLE = `BMAD_S_IDLE;
  localparam [3:0] S_DISP = `BMAD_S_DISP;
  localparam [3:0] S_REGS = `BMAD_S_REGS;
  localparam [3:0] S_DONE = `BMAD_S_DONE;

  reg [3:0] state_r;
  reg [31:0] word_r;
  reg [31:0] ip_r;
  reg [31:0] disp_r;
  reg [1:0] ctrl_r;
  reg fault_sticky_r;
  reg [31:0] dec_count_r;
  reg [31:0] flt_count_r;

  // ----------------------------------------------------------------
  // field extraction from the held word
  // ----------------------------------------------------------------
  wire [7:0] opc = word_r[`BMAD_OPC_HI:`BMAD_OPC_LO];
  wire is_long = word_r[`BMAD_VAR_BIT];
  wire [3:0] lmode = word_r[`BMAD_LMODE_HI:`BMAD_LMODE_LO];
  wire [2:0] scale = word_r[`BMAD_SCALE_HI:`BMAD_SCALE_LO];
  wire [31:0] short_ofs = {20'h00000, word_r[`BMAD_OFS_HI:`BMAD_OFS_LO]};
  wire [21:0] bdisp = word_r[`BMAD_BDISP_HI:`BMAD_BDISP_LO];

  // same fields straight from the fetch port, used when accepting a word
  wire in_long = i_insn_word[`BMAD_VAR_BIT];
  wire [3:0] in_lmode = i_insn_word[`BMAD_LMODE_HI:`BMAD_LMODE_LO];
  wire [2:0] in_scale = i_insn_word[`BMAD_SCALE_HI:`BMAD_SCALE_LO];

  // a word is taken only when valid and ready
  wire take = i_insn_valid & o_insn_ready;

  // ----------------------------------------------------------------
  // reserved encodings
  // ----------------------------------------------------------------
  // long modes that use the index register need a legal scale
  function uses_index;
    input [3:0] m;
    begin
      uses_index = (m == `BMAD_M_BIDX) | (m == `BMAD_M_IDISP) | (m == `BMAD_M_FULL);
    end
  endfunction

  // modes absent from the mode table are treated like the reserved one
  function mode_legal;
    input [3:0] m;
    begin
      mode_legal = (m == `BMAD_M_BASE) | (m == `BMAD_M_IPREL) | (m == `BMAD_M_BIDX) |
                   (m == `BMAD_M_DISP) | (m == `BMAD_M_BDISP) | (m == `BMAD_M_IDISP) |
                   (m == `BMAD_M_FULL);
    end
  endfunction

  // fault check on an arriving long word, so no displacement word is fetched for it
  wire in_fault = in_long & (~mode_legal(in_lmode) |
                  (uses_index(in_lmode) & (in_scale > `BMAD_SCALE_MAX)));
  // displacement word follows modes 0101 and 11xx only
  // branch words never take a second beat, whatever their displacement bits look like
  wire in_needs_disp = (i_insn_fmt == `BMAD_FMT_MEM) & in_long & ~in_fault &
                       ((in_lmode == `BMAD_M_IPREL) | in_lmode[3]);

  // ----------------------------------------------------------------
  // effective address and branch target
  // ----------------------------------------------------------------
  // shifting by the scale code gives the 1..16 multiplier; codes 101..111 are faulted below
  wire [31:0] scaled_idx = i_rf_index_data << scale;
  wire [31:0] bdisp_bytes = {{8{bdisp[21]}}, bdisp, 2'b00};
  wire [31:0] branch_tgt = ip_r + `BMAD_NEXT_ADJ + bdisp_bytes;
  reg [31:0] ea;
  reg ea_fault;

  // address computation per variant and mode
  always @* begin
    ea = 32'h00000000;
    ea_fault = 1'b0;
    if (!is_long) begin
      if (word_r[`BMAD_SMODE_BIT]) begin
        ea = i_rf_base_data + short_ofs;
      end else begin
        ea = short_ofs;
      end
    end else begin
      case (lmode)
        `BMAD_M_BASE: ea = i_rf_base_data;
        `BMAD_M_IPREL: ea = ip_r + disp_r + `BMAD_IP_ADJ;
        `BMAD_M_BIDX: ea = i_rf_base_data + scaled_idx;
        `BMAD_M_DISP: ea = disp_r;
        `BMAD_M_BDISP: ea = i_rf_base_data + disp_r;
        `BMAD_M_IDISP: ea = scaled_idx + disp_r;
        `BMAD_M_FULL: ea = i_rf_base_data + scaled_idx + disp_r;
        default: ea_fault = 1'b1;
      endcase
      if (uses_index(lmode) && (scale > `BMAD_SCALE_MAX)) begin
        ea_fault = 1'b1;
      end
    end
  end

  // extended transfer opcodes steer the target from the memory path
  wire is_xfer_opc = (opc == XBRANCH_OPC) | (opc == XBAL_OPC) | (opc == XCALL_OPC);

  // ----------------------------------------------------------------
  // decode sequence
  // ----------------------------------------------------------------
  // idle takes a word; disp waits for the displacement word; regs reads the
  // register file one cycle after the selects settle; done presents the result
  always @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_r <= S_IDLE;
      word_r <= 32'h00000000;
      ip_r <= 32'h00000000;
      disp_r <= 32'h00000000;
      o_insn_ready <= 1'b0;
      o_rf_base_sel <= 5'h00;
      o_rf_index_sel <= 5'h00;
      o_dec_valid <= 1'b0;
      o_dec_fault <= 1'b0;
      o_dec_is_mem <= 1'b0;
      o_dec_opcode <= 8'h00;
      o_dec_reg <= 5'h00;
      o_dec_addr <= 32'h00000000;
      o_dec_virt <= 1'b0;
      o_dec_xfer <= 1'b0;
      o_dec_target <= 32'h00000000;
    end else begin
      o_dec_valid <= 1'b0;
      case (state_r)
        S_IDLE: begin
          o_insn_ready <= ctrl_r[`BMAD_CTRL_EN];
          if (take) begin
            word_r <= i_insn_word;
            ip_r <= i_insn_addr;
            disp_r <= 32'h00000000;
            o_insn_ready <= in_needs_disp;
            o_rf_base_sel <= i_insn_word[`BMAD_BASE_HI:`BMAD_BASE_LO];
            o_rf_index_sel <= i_insn_word[`BMAD_IDX_HI:`BMAD_IDX_LO];
            if (i_insn_fmt == `BMAD_FMT_BRANCH) begin
              state_r <= S_DONE;
            end else if (in_needs_disp) begin
              state_r <= S_DISP;
            end else begin
              state_r <= S_REGS;
            end
          end
        end
        S_DISP: begin
          if (i_insn_valid) begin
            disp_r <= i_insn_word;
            o_insn_ready <= 1'b0;
            state_r <= S_REGS;
          end
        end
        S_REGS: begin
          o_dec_valid <= 1'b1;
          o_dec_is_mem <= 1'b1;
          o_dec_opcode <= opc;
          o_dec_reg <= word_r[`BMAD_REG_HI:`BMAD_REG_LO];
          o_dec_fault <= ea_fault;
          o_dec_addr <= ea_fault ? 32'h00000000 : ea;
          o_dec_virt <= ctrl_r[`BMAD_CTRL_VIRT];
          o_dec_xfer <= is_xfer_opc & ~ea_fault;
          o_dec_target <= ea_fault ? 32'h00000000 : ea;
          state_r <= S_DONE;
        end
        S_DONE: begin
          // branch words finish here; memory words only pass through
          if (!o_dec_is_mem || !o_dec_valid) begin
            if (!o_dec_valid) begin
              o_dec_valid <= 1'b1;
              o_dec_is_mem <= 1'b0;
              o_dec_opcode <= opc;
              o_dec_reg <= 5'h00;
              o_dec_fault <= 1'b0;
              o_dec_addr <= 32'h00000000;
              o_dec_virt <= ctrl_r[`BMAD_CTRL_VIRT];
              o_dec_xfer <= (opc != RETURN_OPC);
              o_dec_target <= (opc == RETURN_OPC) ? 32'h00000000 : branch_tgt;
            end
          end
          o_insn_ready <= ctrl_r[`BMAD_CTRL_EN];
          state_r <= S_IDLE;
        end
        default: begin
          state_r <= S_IDLE;
          o_insn_ready <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  // one wait state: pready rises in the second access cycle, so read data
  // and the decode of the address both come from flip-flops
  wire acc = i_psel & i_penable;
  wire wr_commit = acc & o_pready & i_pwrite;
  wire addr_ok = (i_paddr == `BMAD_A_CTRL) | (i_paddr == `BMAD_A_STATUS) |
                 (i_paddr == `BMAD_A_LAST_ADDR) | (i_paddr == `BMAD_A_DEC_COUNT) |
                 (i_paddr == `BMAD_A_FLT_COUNT);
  reg [31:0] rd_mux;

  // read selection
  always @* begin
    if (i_paddr == `BMAD_A_CTRL) begin
      rd_mux = {30'h00000000, ctrl_r};
    end else if (i_paddr == `BMAD_A_STATUS) begin
      rd_mux = {30'h00000000, fault_sticky_r, ~state_r[0]};
    end else if (i_paddr == `BMAD_A_LAST_ADDR) begin
      rd_mux = o_dec_addr;
    end else if (i_paddr == `BMAD_A_DEC_COUNT) begin
      rd_mux = dec_count_r;
    end else if (i_paddr == `BMAD_A_FLT_COUNT) begin
      rd_mux = flt_count_r;
    end else begin
      rd_mux = 32'h00000000;
    end
  end

  // handshake and read data
  always @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h00000000;
    end else begin
      o_pready <= acc & ~o_pready;
      o_pslverr <= acc & ~o_pready & ~addr_ok;
      o_prdata <= (acc & ~o_pready & ~i_pwrite) ? rd_mux : 32'h00000000;
    end
  end

  // control, sticky fault flag and counters; a fault in the clearing cycle wins
  always @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ctrl_r <= `BMAD_CTRL_RST;
      fault_sticky_r <= 1'b0;
      dec_count_r <= 32'h00000000;
      flt_count_r <= 32'h00000000;
    end else begin
      if (wr_commit && i_paddr == `BMAD_A_CTRL) begin
        ctrl_r <= i_pwdata[1:0];
      end
      if (o_dec_valid && o_dec_fault) begin
        fault_sticky_r <= 1'b1;
      end else if (wr_commit && i_paddr == `BMAD_A_STATUS && i_pwdata[`BMAD_ST_FAULT]) begin
        fault_sticky_r <= 1'b0;
      end
      if (o_dec_valid) begin
        dec_count_r <= dec_count_r + 32'h00000001;
      end
      if (o_dec_valid && o_dec_fault) begin
        flt_count_r <= flt_count_r + 32'h00000001;
      end
    end
  end

endmodule

//--- design/bmad_map.vh
// field positions, encodings, register offsets and state codes of the branch/memory address decoder
`ifndef BMAD_MAP_VH
`define BMAD_MAP_VH

// ----------------------------------------------------------------
// instruction fields
// ----------------------------------------------------------------
`define BMAD_OPC_HI 31
`define BMAD_OPC_LO 24
`define BMAD_REG_HI 23
`define BMAD_REG_LO 19
`define BMAD_BASE_HI 18
`define BMAD_BASE_LO 14
`define BMAD_SMODE_BIT 13
`define BMAD_VAR_BIT 12
`define BMAD_OFS_HI 11
`define BMAD_OFS_LO 0
`define BMAD_LMODE_HI 13
`define BMAD_LMODE_LO 10
`define BMAD_SCALE_HI 9
`define BMAD_SCALE_LO 7
`define BMAD_IDX_HI 4
`define BMAD_IDX_LO 0
`define BMAD_BDISP_HI 23
`define BMAD_BDISP_LO 2
`define BMAD_BDISP_SIGN 23

// ----------------------------------------------------------------
// long variant modes, scale limit, address adjustments
// ----------------------------------------------------------------
`define BMAD_M_BASE 4'h4
`define BMAD_M_IPREL 4'h5
`define BMAD_M_RSVD 4'h6
`define BMAD_M_BIDX 4'h7
`define BMAD_M_DISP 4'hc
`define BMAD_M_BDISP 4'hd
`define BMAD_M_IDISP 4'he
`define BMAD_M_FULL 4'hf
`define BMAD_SCALE_MAX 3'h4
`define BMAD_IP_ADJ 32'h00000008
`define BMAD_NEXT_ADJ 32'h00000004
`define BMAD_WORD_SHIFT 2

// ----------------------------------------------------------------
// format select at the fetch port
// ----------------------------------------------------------------
`define BMAD_FMT_BRANCH 1'b0
`define BMAD_FMT_MEM 1'b1

// ----------------------------------------------------------------
// apb register offsets (byte addresses) and fields
// ----------------------------------------------------------------
`define BMAD_A_CTRL 12'h000
`define BMAD_A_STATUS 12'h004
`define BMAD_A_LAST_ADDR 12'h008
`define BMAD_A_DEC_COUNT 12'h00c
`define BMAD_A_FLT_COUNT 12'h010
`define BMAD_CTRL_VIRT 0
`define BMAD_CTRL_EN 1
`define BMAD_CTRL_RST 2'h0
`define BMAD_ST_BUSY 0
`define BMAD_ST_FAULT 1

// ----------------------------------------------------------------
// one-hot decode states
// ----------------------------------------------------------------
`define BMAD_S_IDLE 4'h1
`define BMAD_S_DISP 4'h2
`define BMAD_S_REGS 4'h4
`define BMAD_S_DONE 4'h8

`endif

//--- tb/bmad_decoder_properties.sv
// concurrent checks on the decoder ports
`timescale 1ns/10ps
module bmad_decoder_properties #(
  parameter [7:0] RETURN_OPC = 8'h0a
) (
  // clock, reset and apb
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic o_pready,
  input wire logic o_pslverr,
  // fetch and register file
  input wire logic i_insn_valid,
  input wire logic i_insn_fmt,
  input wire logic [31:0] i_insn_word,
  input wire logic [31:0] i_insn_addr,
  input wire logic o_insn_ready,
  input wire logic [4:0] o_rf_base_sel,
  input wire logic [4:0] o_rf_index_sel,
  input wire logic [31:0] i_rf_base_data,
  // result
  input wire logic o_dec_valid,
  input wire logic o_dec_fault,
  input wire logic o_dec_is_mem,
  input wire logic o_dec_xfer,
  input wire logic [7:0] o_dec_opcode,
  input wire logic [4:0] o_dec_reg,
  input wire logic [31:0] o_dec_addr,
  input wire logic [31:0] o_dec_target
);
  logic wait_r;
  logic [31:0] word_r;
  logic [31:0] addr_r;
  logic take;
  logic first;
  logic short_w;
  logic [31:0] br_tgt;
  assign take = i_insn_valid && o_insn_ready;
  assign first = take && !wait_r;
  assign short_w = first && i_insn_fmt && !i_insn_word[12];
  assign br_tgt = addr_r + 32'h4 + {{8{word_r[23]}}, word_r[23:2], 2'b00};
  // a word announcing a displacement makes the next taken word data, not an instruction
  always @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wait_r <= 1'b0;
      word_r <= 32'h0;
      addr_r <= 32'h0;
    end else if (take) begin
      wait_r <= first && i_insn_fmt && (i_insn_word[13:10] == 4'h5 || i_insn_word[13:12] == 2'b11)
        && !(i_insn_word[13:11] == 3'b111 && i_insn_word[9:7] > 3'h4);
      if (first) begin
        word_r <= i_insn_word;
        addr_r <= i_insn_addr;
      end
    end
  end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);
  a_apb_one_wait: assert property (i_psel && i_penable && !o_pready |=> o_pready)
    else $error("apb answer late");
  a_err_with_ready: assert property (o_pslverr |-> o_pready) else $error("error without ready");
  a_valid_pulse: assert property (o_dec_valid |=> !o_dec_valid) else $error("result valid too long");
  a_branch_target: assert property (first && !i_insn_fmt && i_insn_word[31:24] != RETURN_OPC
    |=> ##1 o_dec_valid && o_dec_xfer && o_dec_target == br_tgt) else $error("branch target wrong");
  a_return_notgt: assert property (first && !i_insn_fmt && i_insn_word[31:24] == RETURN_OPC
    |=> ##1 o_dec_valid && !o_dec_xfer && o_dec_target == 32'h0) else $error("return made a target");
  a_short_abs: assert property (short_w && !i_insn_word[13] |=> ##1 o_dec_valid
    && o_dec_addr == {20'h0, word_r[11:0]} && o_dec_opcode == word_r[31:24] && o_dec_reg == word_r[23:19])
    else $error("absolute offset wrong");
  a_short_base: assert property (short_w && i_insn_word[13] |=> ##1 o_dec_valid
    && o_dec_addr == $past(i_rf_base_data) + {20'h0, word_r[11:0]}) else $error("base plus offset wrong");
  a_rf_select: assert property (first && i_insn_fmt
    |=> o_rf_base_sel == word_r[18:14] && o_rf_index_sel == word_r[4:0]) else $error("register select wrong");
  a_long_base: assert property (first && i_insn_fmt && i_insn_word[13:10] == 4'h4
    |=> ##1 o_dec_valid && o_dec_addr == $past(i_rf_base_data)) else $error("base mode wrong");
  a_mode_rsvd: assert property (first && i_insn_fmt && i_insn_word[13:10] == 4'h6
    |=> ##1 o_dec_valid && o_dec_fault) else $error("reserved mode not refused");
  a_scale_rsvd: assert property (first && i_insn_fmt && i_insn_word[13:10] == 4'h7
    && i_insn_word[9:7] > 3'h4 |=> ##1 o_dec_valid && o_dec_fault) else $error("reserved scale not refused");
  a_fault_quiet: assert property (o_dec_valid && o_dec_fault |-> o_dec_addr == 32'h0 && !o_dec_xfer)
    else $error("fault carried an address");
  a_xfer_target: assert property (o_dec_valid && o_dec_is_mem && o_dec_xfer |-> o_dec_target == o_dec_addr)
    else $error("transfer target differs");
endmodule
bind bmad_decoder bmad_decoder_properties #(.RETURN_OPC(RETURN_OPC)) bmad_decoder_properties_i (
  .i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_psel(i_psel), .i_penable(i_penable),
  .o_pready(o_pready), .o_pslverr(o_pslverr), .i_insn_valid(i_insn_valid), .i_insn_fmt(i_insn_fmt),
  .i_insn_word(i_insn_word), .i_insn_addr(i_insn_addr), .o_insn_ready(o_insn_ready),
  .o_rf_base_sel(o_rf_base_sel), .o_rf_index_sel(o_rf_index_sel), .i_rf_base_data(i_rf_base_data),
  .o_dec_valid(o_dec_valid), .o_dec_fault(o_dec_fault), .o_dec_is_mem(o_dec_is_mem), .o_dec_xfer(o_dec_xfer),
  .o_dec_opcode(o_dec_opcode), .o_dec_reg(o_dec_reg), .o_dec_addr(o_dec_addr), .o_dec_target(o_dec_target));

//--- tb/bmad_rf_model.sv
// register file model answering the decoder's base and index read ports
`timescale 1ns/10ps
module bmad_rf_model (
  // read selects from the decoder
  input wire logic [4:0] i_base_sel,
  input wire logic [4:0] i_index_sel,
  // register contents, same cycle
  output logic [31:0] o_base_data,
  output logic [31:0] o_index_data
);
  // distinct contents per register so a wrong select shows up in the address
  assign o_base_data = {3'h0, i_base_sel, 24'h0} + 32'h20;
  assign o_index_data = {3'h0, i_index_sel, 24'h0} + 32'h20;
endmodule

//--- tb/branch_memory_address_decode_test.sv
// self-checking bench for the branch/memory address decoder
`timescale 1ns/10ps
`include "bmad_map.vh"
module branch_memory_address_decode_test;
  logic core_clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic insn_valid = 1'b0, insn_fmt = 1'b0, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, insn_word = 32'h0, insn_addr = 32'h0, rd;
  logic [31:0] prdata, base_data, index_data, dec_addr, dec_target;
  logic pready, pslverr, insn_ready, dec_valid, dec_fault, dec_is_mem, dec_virt, dec_xfer;
  logic [4:0] base_sel, index_sel, dec_reg;
  logic [7:0] dec_opcode;
  int fails = 0, total_checks = 0;
  always #2.5 core_clk = ~core_clk;
  bmad_decoder bmad_decoder_i (.i_core_clk(core_clk), .i_reset_n(reset_n), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_insn_valid(insn_valid), .i_insn_fmt(insn_fmt), .i_insn_word(insn_word),
    .i_insn_addr(insn_addr), .o_insn_ready(insn_ready), .o_rf_base_sel(base_sel), .o_rf_index_sel(index_sel),
    .i_rf_base_data(base_data), .i_rf_index_data(index_data), .o_dec_valid(dec_valid), .o_dec_fault(dec_fault),
    .o_dec_is_mem(dec_is_mem), .o_dec_opcode(dec_opcode), .o_dec_reg(dec_reg), .o_dec_addr(dec_addr),
    .o_dec_virt(dec_virt), .o_dec_xfer(dec_xfer), .o_dec_target(dec_target));
  bmad_rf_model bmad_rf_model_i (.i_base_sel(base_sel), .i_index_sel(index_sel), .o_base_data(base_data),
    .o_index_data(index_data));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rfv(input logic [4:0] s);
    return {3'h0, s, 24'h0} + 32'h20;
  endfunction
  function automatic logic [31:0] lw(input logic [3:0] m, input logic [2:0] sc);
    return {8'h90, 5'd3, 5'd7, m, sc, 2'b00, 5'd9};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // the request holds until pready is seen high; no latency is assumed
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk(pready, 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // one instruction, with its displacement beat when it has one, then wait for the result
  task automatic run(input logic fmt, input logic [31:0] w, input logic [31:0] a, input logic hd,
    input logic [31:0] d);
    int n;
    @(posedge core_clk);
    insn_valid <= 1'b1;
    insn_fmt <= fmt;
    insn_word <= w;
    insn_addr <= a;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (insn_ready !== 1'b1 && n < 40);
    if (hd) begin
      insn_word <= d;
      @(posedge core_clk);
      chk(insn_ready, 1'b1);
    end else begin
      @(posedge core_clk);
      chk(insn_ready, 1'b0);
    end
    insn_valid <= 1'b0;
    insn_word <= ~insn_word;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (dec_valid !== 1'b1 && n < 40);
    chk(dec_valid, 1'b1);
  endtask
  task automatic res(input logic [31:0] ea, input logic xf, input logic fl);
    chk(dec_addr, ea);
    chk(dec_xfer, xf);
    chk(dec_fault, fl);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic s_regs();
    apb(1'b0, `BMAD_A_CTRL, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, 12'h100, 32'hffffffff);
    chk(err, 1'b1);
    apb(1'b1, `BMAD_A_CTRL, 32'h2);
    apb(1'b0, `BMAD_A_CTRL, 32'h0);
    chk(rd, 32'h2);
  endtask
  task automatic s_branch();
    logic [21:0] dv [3] = '{22'h1fffff, 22'h200000, 22'h000003};
    foreach (dv[k]) begin
      run(`BMAD_FMT_BRANCH, {8'h08, dv[k], 2'b11}, 32'h00400000, 1'b0, 32'h0);
      chk(dec_target, 32'h00400004 + {{8{dv[k][21]}}, dv[k], 2'b00});
      res(32'h0, 1'b1, 1'b0);
      chk(dec_opcode, 8'h08);
      chk(dec_reg, 5'h0);
      chk(dec_is_mem, 1'b0);
      chk(dec_virt, 1'b0);
    end
    run(`BMAD_FMT_BRANCH, {8'h0a, 22'h155555, 2'b00}, 32'h1000, 1'b0, 32'h0);
    chk(dec_target, 32'h0);
    chk(dec_xfer, 1'b0);
  endtask
  task automatic s_short();
    apb(1'b1, `BMAD_A_CTRL, 32'h3);
    run(`BMAD_FMT_MEM, {8'h80, 5'd4, 5'd7, 2'b00, 12'hfff}, 32'h2000, 1'b0, 32'h0);
    res(32'h00000fff, 1'b0, 1'b0);
    chk(dec_reg, 5'd4);
    chk(dec_virt, 1'b1);
    chk(dec_opcode, 8'h80);
    run(`BMAD_FMT_MEM, {8'h92, 5'd6, 5'd7, 2'b10, 12'h010}, 32'h2000, 1'b0, 32'h0);
    res(rfv(5'd7) + 32'h10, 1'b0, 1'b0);
    chk(dec_reg, 5'd6);
    chk(dec_is_mem, 1'b1);
    run(`BMAD_FMT_MEM, {8'h84, 5'd0, 5'd2, 2'b10, 12'h004}, 32'h2000, 1'b0, 32'h0);
    res(rfv(5'd2) + 32'h4, 1'b1, 1'b0);
    chk(dec_target, rfv(5'd2) + 32'h4);
  endtask
  task automatic s_long();
    logic [3:0] md [7] = '{4'h4, 4'h5, 4'h7, 4'hc, 4'hd, 4'he, 4'hf};
    logic [31:0] b, x, d, e;
    b = rfv(5'd7);
    d = 32'hfffffff0;
    for (int s = 0; s < 5; s++) begin
      run(`BMAD_FMT_MEM, lw(4'h7, s[2:0]), 32'h3000, 1'b0, 32'h0);
      res(b + (rfv(5'd9) << s), 1'b0, 1'b0);
    end
    x = rfv(5'd9) << 1;
    foreach (md[k]) begin
      e = ((md[k][0] || md[k] == 4'h4) ? b : 32'h0) + (md[k][1] ? x : 32'h0) + (md[k][3] ? d : 32'h0);
      if (md[k] == 4'h5) begin
        e = 32'h3000 + d + 32'h8;
      end
      run(`BMAD_FMT_MEM, lw(md[k], 3'h1), 32'h3000, md[k] == 4'h5 || md[k][3], d);
      res(e, 1'b0, 1'b0);
    end
    run(`BMAD_FMT_MEM, lw(4'h6, 3'h0), 32'h3000, 1'b0, 32'h0);
    res(32'h0, 1'b0, 1'b1);
    for (int s = 5; s < 8; s++) begin
      run(`BMAD_FMT_MEM, lw(4'h7, s[2:0]), 32'h3000, 1'b0, 32'h0);
      res(32'h0, 1'b0, 1'b1);
    end
  endtask
  // fault counter, sticky flag and its write-one clear, after the faulting words of s_long
  task automatic s_status();
    apb(1'b0, `BMAD_A_FLT_COUNT, 32'h0);
    chk(rd, 32'h4);
    apb(1'b0, `BMAD_A_DEC_COUNT, 32'h0);
    chk(rd, 32'h17);
    apb(1'b0, `BMAD_A_STATUS, 32'h0);
    chk(rd, 32'h2);
    apb(1'b1, `BMAD_A_STATUS, 32'h2);
    apb(1'b0, `BMAD_A_STATUS, 32'h0);
    chk(rd, 32'h0);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // main sequence after ten cycles of reset
  initial begin
    repeat (10) @(posedge core_clk);
    reset_n <= 1'b1;
    s_regs();
    s_branch();
    s_short();
    s_long();
    s_status();
    print_verdict();
  end
  // the whole run needs well under a thousand cycles
  initial begin
    #(5 * 20000);
    fails++;
    print_verdict();
  end
endmodule
